//--- common/cfg_init_defines.vh
`ifndef CFG_INIT_DEFINES_VH
`define CFG_INIT_DEFINES_VH

// ****************************************************************
// timing
// ****************************************************************
// power-on dwell before the init pin is driven, in microseconds
`define POR_SLOW_US 40000
`define POR_FAST_US 9000
// clock period in nanoseconds
`define CLK_PERIOD_NS 10
// cycles of memory clearing
`define CLEAR_CYCLES 16'h0040
`define CNT_W 32
`define CNT_ONE 32'h00000001
`define CNT_ZERO 32'h00000000
`define CLR_ONE 16'h0001
`define CLR_ZERO 16'h0000

// ****************************************************************
// mode select
// ****************************************************************
`define MODE_W 3
`define MODE_RST 3'h0

`endif

//--- src/cfg_edge_sync.v
`include "cfg_init_defines.vh"

// two-flop synchroniser with rise and fall pulses taken after the second flop
module cfg_edge_sync (
  // clock and reset
  input wire mclk_i,
  input wire arst_n_i,
  input wire ce_i,
  // async level and its synchronised view
  input wire din_i,
  output reg dout_o,
  output wire rise_o,
  output wire fall_o
);

  reg meta_r;
  reg last_r;

  // first flop feeds only the second; reset state is released-high
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= 1'b1;
      dout_o <= 1'b1;
      last_r <= 1'b1;
    end else if (ce_i) begin
      meta_r <= din_i;
      dout_o <= meta_r;
      last_r <= dout_o;
    end
  end

  // edges of the synchronised level
  assign rise_o = ce_i & dout_o & ~last_r;
  assign fall_o = ce_i & ~dout_o & last_r;

endmodule // cfg_edge_sync

//--- src/config_reset_init_control.v
`include "cfg_init_defines.vh"

module config_reset_init_control #(
  parameter POR_SLOW_CYC = (`POR_SLOW_US * 1000) / `CLK_PERIOD_NS,
  parameter POR_FAST_CYC = (`POR_FAST_US * 1000) / `CLK_PERIOD_NS
) (
  // clock, reset, enable
  input wire mclk_i,
  input wire arst_n_i,
  input wire ce_i,
  // configuration reset pin, active low
  input wire prog_n_i,
  // init pin, open drain
  input wire init_n_i,
  output reg init_n_o,
  output reg init_n_oe_o,
  // options and mode
  input wire por_fast_select_i,
  input wire [2:0] mode_sel_i,
  // configuration engine handshake
  input wire cfg_error_i,
  input wire cfg_done_i,
  input wire err_on_init_en_i,
  output reg cfg_start_o,
  output reg [2:0] cfg_mode_o,
  output reg cfg_clear_o,
  output reg jtag_limit_o,
  output reg configured_o
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam S_POR = 6'h01;
  localparam S_RESET = 6'h02;
  localparam S_CLEAR = 6'h04;
  localparam S_WAIT = 6'h08;
  localparam S_CONFIG = 6'h10;
  localparam S_DONE = 6'h20;

  reg [5:0] state_r;
  reg [5:0] state_nxt;
  reg [`CNT_W-1:0] por_cnt_r;
  reg [15:0] clr_cnt_r;
  reg err_r;

  wire prog_s;
  wire prog_rise;
  wire prog_fall;
  wire init_s;
  wire [`CNT_W-1:0] por_limit;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  cfg_edge_sync u_prog_sync (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .din_i(prog_n_i),
    .dout_o(prog_s),
    .rise_o(prog_rise),
    .fall_o(prog_fall)
  );

  cfg_edge_sync u_init_sync (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .din_i(init_n_i),
    .dout_o(init_s),
    .rise_o(),
    .fall_o()
  );

  // power-on dwell picked by the fast option
  assign por_limit = por_fast_select_i ? POR_FAST_CYC[`CNT_W-1:0] :
                     POR_SLOW_CYC[`CNT_W-1:0];

  // ****************************************************************
  // sequence
  // ****************************************************************
  // next-state logic; a prog fall always wins
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_POR: begin
        if (por_cnt_r >= por_limit - `CNT_ONE) begin
          state_nxt = S_CLEAR;
        end
      end
      S_RESET: begin
        if (prog_rise) begin
          state_nxt = S_CLEAR;
        end
      end
      S_CLEAR: begin
        if (clr_cnt_r >= `CLEAR_CYCLES - `CLR_ONE) begin
          state_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        // stall while prog or init is held low from outside
        if (prog_s && init_s) begin
          state_nxt = S_CONFIG;
        end
      end
      S_CONFIG: begin
        if (cfg_done_i) begin
          state_nxt = S_DONE;
        end
      end
      S_DONE: begin
        state_nxt = S_DONE;
      end
      default: begin
        state_nxt = S_POR;
      end
    endcase
    if (prog_fall) begin
      state_nxt = S_RESET;
    end
  end

  // state, counters and registered outputs
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r <= S_POR;
      por_cnt_r <= `CNT_ZERO;
      clr_cnt_r <= `CLR_ZERO;
      err_r <= 1'b0;
      init_n_o <= 1'b0;
      init_n_oe_o <= 1'b0;
      cfg_start_o <= 1'b0;
      cfg_mode_o <= `MODE_RST;
      cfg_clear_o <= 1'b0;
      jtag_limit_o <= 1'b0;
      configured_o <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      por_cnt_r <= (state_r == S_POR) ? por_cnt_r + `CNT_ONE : `CNT_ZERO;
      clr_cnt_r <= (state_r == S_CLEAR) ? clr_cnt_r + `CLR_ONE : `CLR_ZERO;
      // error is sticky until the next reset sequence
      if (state_nxt == S_RESET || state_nxt == S_CLEAR) begin
        err_r <= 1'b0;
      end else if (cfg_error_i && (state_r == S_CONFIG ||
                   (state_r == S_DONE && err_on_init_en_i))) begin
        err_r <= 1'b1;
      end
      // pin is only ever pulled low, never driven high
      init_n_o <= 1'b0;
      init_n_oe_o <= (state_nxt == S_RESET) || (state_nxt == S_CLEAR) ||
                     (err_r && state_nxt != S_WAIT);
      cfg_clear_o <= (state_nxt == S_RESET) || (state_nxt == S_CLEAR);
      cfg_start_o <= (state_r == S_WAIT) && (state_nxt == S_CONFIG);
      if (state_r == S_WAIT && state_nxt == S_CONFIG) begin
        cfg_mode_o <= mode_sel_i;
      end
      jtag_limit_o <= ~prog_s;
      configured_o <= (state_nxt == S_DONE);
    end
  end

endmodule // config_reset_init_control

//--- tb/board_model.sv
module board_model (
  input wire logic init_n_o,
  input wire logic init_n_oe_o,
  input wire logic hold_low_i,
  output wire logic init_w_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up wins unless the device or the board pulls low
  assign init_w_o = !((init_n_oe_o && !init_n_o) || hold_low_i);
endmodule // board_model

//--- tb/cfg_init_properties.sv
module cfg_init_checker (
  input wire mclk_i,
  input wire arst_n_i,
  input wire ce_i,
  input wire prog_n_i,
  input wire init_n_i,
  input wire init_n_o,
  input wire init_n_oe_o,
  input wire [2:0] mode_sel_i,
  input wire cfg_error_i,
  input wire err_on_init_en_i,
  input wire cfg_start_o,
  input wire [2:0] cfg_mode_o,
  input wire cfg_clear_o,
  input wire jtag_limit_o,
  input wire configured_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  // a frozen clock enable stops the sequence, so checks pause with it
  default disable iff (!arst_n_i || !ce_i);
  AST_OPEN_DRAIN: assert property (init_n_o == 1'h0) else $error("init value high");
  AST_PROG_FALL: assert property ($fell(prog_n_i) |-> ##[2:4] init_n_oe_o && cfg_clear_o)
    else $error("no clear after fall");
  AST_HOLD_LOW: assert property (!prog_n_i [*5] |-> init_n_oe_o) else $error("init released");
  AST_JTAG_ON: assert property (!prog_n_i [*4] |-> jtag_limit_o) else $error("jtag open");
  AST_START_MODE: assert property (cfg_start_o |-> cfg_mode_o == $past(mode_sel_i))
    else $error("mode wrong");
  AST_START_INIT: assert property (cfg_start_o |-> $past(init_n_i, 2) && $past(prog_n_i, 2))
    else $error("start while held");
  AST_START_PULSE: assert property (cfg_start_o |=> !cfg_start_o) else $error("long start");
  AST_ERR_PIN: assert property (configured_o && cfg_error_i && err_on_init_en_i |->
    ##[1:3] init_n_oe_o) else $error("error not shown");
  cover property ($rose(cfg_start_o));
  cover property (configured_o && cfg_error_i);
  cover property (!init_n_i && !init_n_oe_o);
endmodule // cfg_init_checker

bind config_reset_init_control cfg_init_checker u_chk (.*);

//--- tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLOW = 20;
  localparam int FAST = 10;
  logic mclk_i = 0, arst_n_i = 0, prog_n_i = 1, hold = 1, fast = 0;
  logic err = 0, done = 0, err_en = 0, ce = 1;
  logic [2:0] mode = 3'h0;
  wire init_w, init_o, oe, start, clr, jtag, cfgd;
  wire [2:0] cmode;
  int num_errors = 0, checks_done = 0;
  logic [2:0] exp_q[$];
  always #5 mclk_i = ~mclk_i;
  config_reset_init_control #(.POR_SLOW_CYC(SLOW), .POR_FAST_CYC(FAST)) dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce), .prog_n_i(prog_n_i), .init_n_i(init_w),
    .init_n_o(init_o), .init_n_oe_o(oe), .por_fast_select_i(fast), .mode_sel_i(mode),
    .cfg_error_i(err), .cfg_done_i(done), .err_on_init_en_i(err_en), .cfg_start_o(start),
    .cfg_mode_o(cmode), .cfg_clear_o(clr), .jtag_limit_o(jtag), .configured_o(cfgd));
  board_model partner (.init_n_o(init_o), .init_n_oe_o(oe), .hold_low_i(hold), .init_w_o(init_w));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (e !== g) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // bounded wait until every expected start was seen
  task automatic drain();
    for (int k = 0; k < 300 && exp_q.size() > 0; k++) cyc(1);
    if (exp_q.size() > 0) begin
      num_errors++;
      complete_run();
    end
  endtask
  // power-up with the init pin held low by the board
  task automatic por(logic f, int p);
    int k;
    arst_n_i <= 0;
    fast <= f;
    hold <= 1;
    cyc(2);
    arst_n_i <= 1;
    for (k = 0; k < 200 && oe !== 1'b1; k++) cyc(1);
    chk("dwell", 1, k >= p && k <= p + 4);
    cyc(120);
    exp_q.push_back(mode);
    hold <= 0;
    drain();
    $display("power-up test done");
  endtask
  // each start is compared against the oldest noted mode
  always @(negedge mclk_i) if (start === 1'b1) begin
    if (exp_q.size() == 0) chk("early start", 0, 1);
    else chk("mode", exp_q.pop_front(), cmode);
  end
  initial begin
    void'($urandom(8564));
    por(0, SLOW);
    por(1, FAST);
    // clock enable low freezes the block: a prog pulse inside it is never seen
    ce <= 0;
    prog_n_i <= 0;
    cyc(6);
    chk("frozen jtag", 0, jtag);
    chk("frozen clear", 0, clr);
    prog_n_i <= 1;
    cyc(1);
    ce <= 1;
    cyc(3);
    $display("freeze test done");
    for (int m = 0; m < 8; m++) begin
      done <= 1;
      err_en <= m[0];
      cyc(2);
      chk("configured", 1, cfgd);
      err <= 1;
      cyc(4);
      chk("error pin", !m[0], init_w);
      prog_n_i <= 0;
      {done, err} <= 2'h0;
      mode <= m[2:0];
      cyc(5);
      chk("jtag", 1, jtag);
      chk("init low", 0, init_w);
      chk("cleared", 0, cfgd);
      cyc($urandom_range(0, 6));
      prog_n_i <= 1;
      exp_q.push_back(m[2:0]);
      drain();
      $display("mode %0d test done", m);
    end
    complete_run();
  end
endmodule // tb
